// >>> rtl/wit_defines.vh
/*
 * Constants for the watch/interval timer: control register address,
 * field positions, reset value, divider widths and tap selection codes.
 * Assumes inclusion by bare name from the design file in rtl/.
 */
`ifndef WIT_DEFINES_VH
`define WIT_DEFINES_VH

// control register location on the processor's data space
`define WIT_CTRL_ADDR 16'hff4a
`define WIT_ADDR_W 16
`define WIT_DATA_W 8

// control register reset value and writable-bit mask
`define WIT_CTRL_RST 8'h00
`define WIT_CTRL_MASK 8'h73

// control field positions
`define WIT_BIT_ENABLE 0
`define WIT_BIT_RUN 1
`define WIT_SEL_LO 4
`define WIT_SEL_HI 6
`define WIT_SEL_W 3

// divider chain: base divider feeds the 9-bit prescaler
`define WIT_BASE_W 7
`define WIT_BASE_MAX 7'h7f
`define WIT_PRE_W 9
`define WIT_PRE_MAX 9'h1ff
`define WIT_CNT_W 5
`define WIT_CNT_MAX 5'h1f
`define WIT_CNT_ZERO 5'h00

// interval codes: prescaler tap masks for 2^11 .. 2^16 clock periods
`define WIT_SEL_2E11 3'h0
`define WIT_SEL_2E12 3'h1
`define WIT_SEL_2E13 3'h2
`define WIT_SEL_2E14 3'h3
`define WIT_SEL_2E15 3'h4
`define WIT_SEL_2E16 3'h5
`define WIT_MASK_2E11 9'h00f
`define WIT_MASK_2E12 9'h01f
`define WIT_MASK_2E13 9'h03f
`define WIT_MASK_2E14 9'h07f
`define WIT_MASK_2E15 9'h0ff
`define WIT_MASK_2E16 9'h1ff
`define WIT_MASK_NONE 9'h000

// nominal system clock the figures above are scaled for, in kHz
`define WIT_SYSCLK_KHZ 8380

`endif

// >>> rtl/wit_watch_timer.v
/*
 * Watch timer with interval timer: a 7-bit base divider and a 9-bit
 * prescaler, both on the system clock, feed a 5-bit watch counter and
 * a selectable interval tap. One 8-bit control register, written by the
 * processor with whole-byte or single-bit writes, read back on request.
 * Assumes the processor port is synchronous to mclk_i.
 */
// Operation
// - nine-bit prescaler on system clock; five-bit counter controlled apart
// - watch interrupt every quarter second at nominal system clock
// - interval interrupt every 2^11..2^16 clocks; codes six, seven idle
// - watch and interval interrupts run concurrently from shared prescaler
// - reset clears whole control register to zero
// - enable bit low holds prescaler and counter cleared
// - run bit low stops and clears the five-bit counter
// - both bits high start watch; both low clear and halt
// - clearing run alone restarts watch count, prescaler keeps running
// - first watch interrupt one prescaler cycle late, later ones exact
// - control register takes single-bit and whole-byte writes
`include "wit_defines.vh"

module wit_watch_timer (
    // clock and reset
    input wire mclk_i,
    input wire rstn_i,
    // processor access
    input wire [`WIT_ADDR_W-1:0] cpu_addr_i,
    input wire cpu_wr_byte_i,
    input wire [`WIT_DATA_W-1:0] cpu_wdata_i,
    input wire cpu_wr_bit_i,
    input wire [2:0] cpu_bit_sel_i,
    input wire cpu_bit_val_i,
    input wire cpu_rd_i,
    output reg [`WIT_DATA_W-1:0] cpu_rdata_o,
    // interrupt requests
    output reg watch_tick_irq_o,
    output reg interval_tick_irq_o
);

    wire addr_hit;
    reg [`WIT_DATA_W-1:0] watch_control_reg_r;
    reg [`WIT_DATA_W-1:0] ctrl_nxt;
    wire watch_block_enable;
    wire tick_counter_run;
    wire [`WIT_SEL_W-1:0] interval_sel;

    reg [`WIT_BASE_W-1:0] base_r;
    reg [`WIT_PRE_W-1:0] pre_r;
    reg [`WIT_CNT_W-1:0] cnt_r;
    reg armed_r;
    wire base_tick;
    wire pre_wrap;
    reg [`WIT_PRE_W-1:0] tap_mask;
    wire interval_done;
    wire watch_done;

    assign addr_hit = (cpu_addr_i == `WIT_CTRL_ADDR);

    // register write: byte write wins over a simultaneous bit write
    always @* begin
        ctrl_nxt = watch_control_reg_r;
        if (addr_hit && cpu_wr_byte_i) begin
            ctrl_nxt = cpu_wdata_i;
        end else if (addr_hit && cpu_wr_bit_i) begin
            ctrl_nxt[cpu_bit_sel_i] = cpu_bit_val_i;
        end
        // reserved positions never store a one
        ctrl_nxt = ctrl_nxt & `WIT_CTRL_MASK;
    end

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            watch_control_reg_r <= `WIT_CTRL_RST;
        end else begin
            watch_control_reg_r <= ctrl_nxt;
        end
    end

    assign watch_block_enable = watch_control_reg_r[`WIT_BIT_ENABLE];
    assign tick_counter_run = watch_control_reg_r[`WIT_BIT_RUN];
    assign interval_sel = watch_control_reg_r[`WIT_SEL_HI:`WIT_SEL_LO];

    // read port: data stands one cycle after the read strobe
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_rdata_o <= `WIT_CTRL_RST;
        end else if (cpu_rd_i) begin
            if (addr_hit) begin
                cpu_rdata_o <= watch_control_reg_r;
            end else begin
                cpu_rdata_o <= `WIT_CTRL_RST;
            end
        end
    end

    // divider chain: base divider then 9-bit prescaler
    assign base_tick = (base_r == `WIT_BASE_MAX);
    assign pre_wrap = base_tick && (pre_r == `WIT_PRE_MAX);

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            base_r <= {`WIT_BASE_W{1'b0}};
            pre_r <= {`WIT_PRE_W{1'b0}};
        end else if (!watch_block_enable) begin
            base_r <= {`WIT_BASE_W{1'b0}};
            pre_r <= {`WIT_PRE_W{1'b0}};
        end else begin
            base_r <= base_r + 1'b1;
            if (base_tick) begin
                pre_r <= pre_r + 1'b1;
            end
        end
    end

    // tap selection for the interval timer
    always @* begin
        case (interval_sel)
            `WIT_SEL_2E11: tap_mask = `WIT_MASK_2E11;
            `WIT_SEL_2E12: tap_mask = `WIT_MASK_2E12;
            `WIT_SEL_2E13: tap_mask = `WIT_MASK_2E13;
            `WIT_SEL_2E14: tap_mask = `WIT_MASK_2E14;
            `WIT_SEL_2E15: tap_mask = `WIT_MASK_2E15;
            `WIT_SEL_2E16: tap_mask = `WIT_MASK_2E16;
            default: tap_mask = `WIT_MASK_NONE;
        endcase
    end

    // prohibited codes give an empty mask and therefore no interval tick
    assign interval_done = watch_block_enable && base_tick &&
        (tap_mask != `WIT_MASK_NONE) &&
        ((pre_r & tap_mask) == tap_mask);

    // watch counter: first prescaler period after start only arms it
    // gated so no pulse escapes in the cycle after disable
    assign watch_done = watch_block_enable && tick_counter_run &&
        pre_wrap && armed_r && (cnt_r == `WIT_CNT_MAX);

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= `WIT_CNT_ZERO;
            armed_r <= 1'b0;
        end else if (!watch_block_enable || !tick_counter_run) begin
            // prescaler keeps running when only run is low
            cnt_r <= `WIT_CNT_ZERO;
            armed_r <= 1'b0;
        end else if (pre_wrap) begin
            if (armed_r) begin
                cnt_r <= cnt_r + 1'b1;
            end
            armed_r <= 1'b1;
        end
    end

    // interrupt pulses, one cycle each
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            watch_tick_irq_o <= 1'b0;
            interval_tick_irq_o <= 1'b0;
        end else begin
            watch_tick_irq_o <= watch_done;
            interval_tick_irq_o <= interval_done;
        end
    end

endmodule // wit_watch_timer

// >>> tb/wit_props.sv
/* Port checker for the watch/interval timer.
   Assumes it is bound to every instance of wit_watch_timer. */
module wit_props (
    // clock, reset, strobes, interrupts
    input logic mclk_i, rstn_i, cpu_wr_byte_i, cpu_wr_bit_i, cpu_rd_i,
    input logic cpu_bit_val_i, watch_tick_irq_o, interval_tick_irq_o,
    // buses
    input logic [15:0] cpu_addr_i,
    input logic [7:0] cpu_wdata_i, cpu_rdata_o,
    input logic [2:0] cpu_bit_sel_i
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    wire sel = cpu_addr_i == 16'hff4a;
    wire rdc = cpu_rd_i && sel && !cpu_wr_byte_i && !cpu_wr_bit_i;
    a_watch_gap:
        assert property (watch_tick_irq_o |=> !watch_tick_irq_o[*8])
        else $error("watch pulse too close");
    a_intv_gap:
        assert property (interval_tick_irq_o |=> !interval_tick_irq_o[*8])
        else $error("interval pulse too close");
    a_rd_hold:
        assert property (!cpu_rd_i |=> $stable(cpu_rdata_o))
        else $error("read data moved");
    a_rd_unmapped:
        assert property (cpu_rd_i && !sel |=> cpu_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rd_zero_bits:
        assert property (cpu_rd_i |=> (cpu_rdata_o & 8'h8c) == 8'h00)
        else $error("fixed bits not zero");
    a_byte_wr:
        assert property (cpu_wr_byte_i && sel ##1
            !cpu_wr_byte_i && !cpu_wr_bit_i ##1 rdc |=>
            cpu_rdata_o == ($past(cpu_wdata_i, 3) & 8'h73))
        else $error("byte write lost");
    a_bit_wr:
        assert property (cpu_wr_bit_i && !cpu_wr_byte_i && sel &&
            cpu_bit_sel_i == 3'h1 ##1
            !cpu_wr_byte_i && !cpu_wr_bit_i ##1 rdc |=>
            cpu_rdata_o[1] == $past(cpu_bit_val_i, 3))
        else $error("bit write lost");
    a_off_quiet:
        assert property (cpu_wr_byte_i && sel && !cpu_wdata_i[0] |-> ##2
            (!watch_tick_irq_o && !interval_tick_irq_o)[*6])
        else $error("pulse while disabled");
endmodule // wit_props

bind wit_watch_timer wit_props wit_props_inst (.*);

// >>> tb/wit_watch_timer_bench.sv
/* Self-checking bench for the watch/interval timer.
   Assumes the design and tb/wit_props.sv are compiled first. */
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    n_mismatch++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module wit_watch_timer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 0, rstn_i = 0, cpu_wr_byte_i = 0, cpu_wr_bit_i = 0;
    logic cpu_bit_val_i = 0, cpu_rd_i = 0;
    logic [15:0] cpu_addr_i = 16'hff4a;
    logic [7:0] cpu_wdata_i = 8'h00;
    logic [2:0] cpu_bit_sel_i = 3'h0;
    wire [7:0] cpu_rdata_o;
    wire watch_tick_irq_o, interval_tick_irq_o;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    wit_watch_timer wit_watch_timer_inst (.*);
    initial forever #12.5 mclk_i = ~mclk_i;
    // tasks start and end at a rising edge; one idle edge after each
    task wr(input [7:0] d);
        cpu_wdata_i <= d;
        cpu_wr_byte_i <= 1'b1;
        @(posedge mclk_i);
        cpu_wr_byte_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task bw(input [2:0] s, input v);
        cpu_bit_sel_i <= s;
        cpu_bit_val_i <= v;
        cpu_wr_bit_i <= 1'b1;
        @(posedge mclk_i);
        cpu_wr_bit_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task rd(input [15:0] a, input [7:0] e);
        cpu_addr_i <= a;
        cpu_rd_i <= 1'b1;
        @(posedge mclk_i);
        cpu_rd_i <= 1'b0;
        cpu_addr_i <= 16'hff4a;
        @(negedge mclk_i);
        `CHK(cpu_rdata_o, e)
        @(posedge mclk_i);
    endtask
    task t_regs;
        rd(16'hff4a, 8'h00);
        wr(8'hff);
        rd(16'hff4a, 8'h73);
        bw(3'h7, 1'b1);
        bw(3'h1, 1'b0);
        rd(16'hff4a, 8'h71);
        rd(16'hff4b, 8'h00);
    endtask
    // odd codes also run the watch counter alongside
    task t_period(input [2:0] c);
        int n;
        n = 0;
        wr(8'h00);
        wr({1'b0, c, 2'h0, c[0], 1'b1});
        while (interval_tick_irq_o !== 1'b1 && n < 70000) begin
            @(negedge mclk_i);
            n++;
        end
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (interval_tick_irq_o !== 1'b1 && n < 70000);
        `CHK(n, 32'd1 << (11 + c))
        @(posedge mclk_i);
    endtask
    task t_quiet(input [7:0] d);
        int k;
        k = 0;
        wr(d);
        repeat (3) @(negedge mclk_i);
        repeat (5000) begin
            @(negedge mclk_i);
            if (watch_tick_irq_o !== 1'b0 || interval_tick_irq_o !== 1'b0)
                k++;
        end
        `CHK(k, 0)
        @(posedge mclk_i);
    endtask
    task final_report;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            final_report;
        end
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_regs;
        for (int c = 0; c < 4; c++) t_period(3'(c));
        t_quiet(8'h00);
        t_quiet(8'h63);
        final_report;
    end
endmodule // wit_watch_timer_bench
